// >>> src/modbus_param_defines.svh
// Constants for the Modbus parameter access block: function codes,
// register map, frame layout and check-sum settings.
// Assumes inclusion by bare name from the design files.
`ifndef MODBUS_PARAM_DEFINES_SVH
`define MODBUS_PARAM_DEFINES_SVH

// ==========================================================
// Function codes
`define FC_READ_HOLDING 8'h03
`define FC_WRITE_SINGLE 8'h06

// ==========================================================
// Register map
`define ARRAY_INDEX_ADDR 16'h0008
`define ARRAY_INDEX_RESET 16'h0000
`define PARAM_ADDR_SCALE 17'h0000A
`define PARAM_ADDR_BIAS 17'h00001

// ==========================================================
// Frame layout
`define REQ_FRAME_LEN 4'h8
`define ECHO_HDR_LEN 4'h6
`define READ_HDR_LEN 4'h3

// ==========================================================
// Check-sum
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'hA001
`define CRC_GOOD 16'h0000

`endif

// >>> src/modbus_param_pkg.sv
// Types shared by the Modbus parameter access block.
// Assumes nothing of its surroundings.
package modbus_param_pkg;

  // ==========================================================
  // Handler states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_CHECK = 3'h1,
    ST_EXEC  = 3'h3,
    ST_HDR   = 3'h2,
    ST_FETCH = 3'h6,
    ST_WAIT  = 3'h7,
    ST_DATA  = 3'h5,
    ST_CRC   = 3'h4
  } handler_state_t;

  // Register address split into parameter number and word slot
  typedef struct packed {
    logic [15:0] num;
    logic [3:0] slot;
  } reg_decode_t;

endpackage

// >>> src/crc16_unit.sv
// Byte-wide Modbus RTU check-sum register.
// Assumes the caller never asserts init and feed in the same cycle.
`timescale 1ns/100ps
`include "modbus_param_defines.svh"

module crc16_unit (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic init_in,
  input wire logic feed_in,
  input wire logic [7:0] byte_in,
  output logic [15:0] crc_out
);

  logic [15:0] crc_reg; // Running remainder
  logic [15:0] crc_next; // Next remainder

  // ==========================================================
  // Next value: eight reflected shift steps per byte
  always_comb begin
    crc_next = crc_reg;
    if (init_in) begin
      crc_next = `CRC_INIT;
    end else if (feed_in) begin
      crc_next = crc_reg ^ {8'h00, byte_in};
      for (int i = 0; i < 8; i++) begin
        // Reflected polynomial, so the low bit leaves first
        crc_next = crc_next[0] ? ((crc_next >> 1) ^ `CRC_POLY) : (crc_next >> 1);
      end
    end
  end

  // Register only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      crc_reg <= `CRC_INIT;
    end else begin
      crc_reg <= crc_next;
    end
  end

  assign crc_out = crc_reg;

endmodule

// >>> src/modbus_parameter_access.sv
// Modbus RTU slave request handler mapping drive parameters onto
// holding registers. Bytes arrive already deframed from a serial
// receiver on the same clock; the parameter store answers reads in
// the cycle its read strobe is high.
`timescale 1ns/100ps
`include "modbus_param_defines.svh"

module modbus_parameter_access
  import modbus_param_pkg::*;
#(
  parameter int MAX_READ_REGS = 125
) (
  input wire logic CLOCK_IN,
  input wire logic RESETN_IN,
  input wire logic [7:0] SLAVE_ADDR_IN,
  input wire logic [7:0] RX_BYTE_IN,
  input wire logic RX_VALID_IN,
  input wire logic RX_END_IN,
  output logic [7:0] TX_BYTE_OUT,
  output logic TX_VALID_OUT,
  input wire logic TX_READY_IN,
  output logic [15:0] PARAM_NUM_OUT,
  output logic [15:0] PARAM_INDEX_OUT,
  output logic PARAM_RD_OUT,
  input wire logic [31:0] PARAM_RDATA_IN,
  input wire logic PARAM_WIDE_IN,
  output logic PARAM_WR_OUT,
  output logic PARAM_LOW_WORD_OUT,
  output logic [15:0] PARAM_WDATA_OUT
);

  // ==========================================================
  // Helpers
  function automatic reg_decode_t decode_addr(input logic [15:0] a);
    logic [16:0] biased;
    biased = {1'b0, a} + `PARAM_ADDR_BIAS;
    decode_addr.num = 16'(biased / `PARAM_ADDR_SCALE);
    decode_addr.slot = 4'(biased % `PARAM_ADDR_SCALE);
  endfunction

  // ==========================================================
  // Reset release
  logic rst_meta_reg; // First stage, read only by the second
  logic rst_n; // Released reset for the block
  always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // State
  handler_state_t state_reg, state_next; // Handler phase
  logic [7:0] buf_reg [0:7]; // Request bytes
  logic [7:0] buf_next [0:7];
  logic [3:0] rx_cnt_reg, rx_cnt_next; // Bytes received, saturating at 9
  logic [3:0] k_reg, k_next; // Byte position inside a phase
  logic [15:0] addr_reg, addr_next; // Current register address
  logic [15:0] left_reg, left_next; // Registers still to return
  logic [15:0] word_reg, word_next; // Register word being sent
  logic [15:0] idx_reg, idx_next; // Array element index
  logic [7:0] tx_byte_reg, tx_byte_next;
  logic tx_valid_reg, tx_valid_next;
  logic [15:0] num_reg, num_next;
  logic rd_reg, rd_next, wr_reg, wr_next, low_reg, low_next;
  logic [15:0] wdata_reg, wdata_next;
  logic crc_init, crc_feed; // Check-sum controls
  logic [7:0] crc_byte; // Byte into the check-sum
  logic [15:0] crc; // Running check-sum
  logic frame_ok; // Request passed all checks
  logic [15:0] req_addr, req_word; // Address and data fields
  reg_decode_t dec; // Decoded current address

  assign req_addr = {buf_reg[2], buf_reg[3]};
  assign req_word = {buf_reg[4], buf_reg[5]};
  assign dec = decode_addr(addr_reg);

  // Residual of zero means the trailing check bytes matched
  assign frame_ok = (rx_cnt_reg == `REQ_FRAME_LEN) && (crc == `CRC_GOOD)
    && (buf_reg[0] == SLAVE_ADDR_IN)
    && ((buf_reg[1] == `FC_WRITE_SINGLE)
      || ((buf_reg[1] == `FC_READ_HOLDING) && (req_word != 16'h0000)
        && (req_word <= 16'(MAX_READ_REGS))));

  crc16_unit crc_u (
    .clk_in(CLOCK_IN),
    .rst_n_in(rst_n),
    .init_in(crc_init),
    .feed_in(crc_feed),
    .byte_in(crc_byte),
    .crc_out(crc)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    state_next = state_reg;
    buf_next = buf_reg;
    rx_cnt_next = rx_cnt_reg;
    k_next = k_reg;
    addr_next = addr_reg;
    left_next = left_reg;
    word_next = word_reg;
    idx_next = idx_reg;
    tx_byte_next = tx_byte_reg;
    tx_valid_next = tx_valid_reg;
    num_next = num_reg;
    rd_next = 1'b0;
    wr_next = 1'b0;
    low_next = low_reg;
    wdata_next = wdata_reg;
    crc_init = 1'b0;
    crc_feed = 1'b0;
    crc_byte = RX_BYTE_IN;
    case (state_reg)
      ST_IDLE: begin
        // Collect bytes; overlong frames saturate and fail the length check
        if (RX_END_IN) begin
          state_next = ST_CHECK;
        end else if (RX_VALID_IN) begin
          crc_feed = 1'b1;
          if (rx_cnt_reg < `REQ_FRAME_LEN) begin
            buf_next[rx_cnt_reg[2:0]] = RX_BYTE_IN;
          end
          if (rx_cnt_reg <= `REQ_FRAME_LEN) begin
            rx_cnt_next = rx_cnt_reg + 4'h1;
          end
        end
      end
      ST_CHECK: begin
        crc_init = 1'b1;
        rx_cnt_next = 4'h0;
        k_next = 4'h0;
        addr_next = req_addr;
        left_next = req_word;
        // Silent discard, no answer at all
        state_next = frame_ok ? ST_EXEC : ST_IDLE;
      end
      ST_EXEC: begin
        state_next = ST_HDR;
        if (buf_reg[1] == `FC_WRITE_SINGLE) begin
          if (req_addr == `ARRAY_INDEX_ADDR) begin
            idx_next = req_word;
          end else begin
            // Slot 1 is the low word of a wide parameter
            num_next = dec.num;
            low_next = (dec.slot == 4'h1);
            wdata_next = req_word;
            wr_next = 1'b1;
          end
        end
      end
      ST_HDR, ST_DATA, ST_CRC: begin
        // Hold the byte until the transmitter takes it
        if (!tx_valid_reg) begin
          tx_valid_next = 1'b1;
          if (state_reg == ST_CRC) begin
            // Check bytes go low first
            tx_byte_next = (k_reg == 4'h0) ? crc[7:0] : crc[15:8];
          end else if (state_reg == ST_DATA) begin
            // Raw word, high byte first
            tx_byte_next = (k_reg == 4'h0) ? word_reg[15:8] : word_reg[7:0];
          end else if (buf_reg[1] == `FC_READ_HOLDING && k_reg == 4'h2) begin
            tx_byte_next = {left_reg[6:0], 1'b0};
          end else begin
            tx_byte_next = buf_reg[k_reg[2:0]];
          end
          crc_feed = (state_reg != ST_CRC);
          crc_byte = tx_byte_next;
        end else if (TX_READY_IN) begin
          tx_valid_next = 1'b0;
          k_next = k_reg + 4'h1;
          if (state_reg == ST_HDR) begin
            if (buf_reg[1] == `FC_WRITE_SINGLE && k_reg == `ECHO_HDR_LEN - 4'h1) begin
              state_next = ST_CRC;
              k_next = 4'h0;
            end else if (buf_reg[1] == `FC_READ_HOLDING
                && k_reg == `READ_HDR_LEN - 4'h1) begin
              state_next = ST_FETCH;
              k_next = 4'h0;
            end
          end else if (state_reg == ST_DATA && k_reg == 4'h1) begin
            k_next = 4'h0;
            addr_next = addr_reg + 16'h0001;
            left_next = left_reg - 16'h0001;
            state_next = (left_reg == 16'h0001) ? ST_CRC : ST_FETCH;
          end else if (state_reg == ST_CRC && k_reg == 4'h1) begin
            crc_init = 1'b1;
            k_next = 4'h0;
            state_next = ST_IDLE;
          end
        end
      end
      ST_FETCH: begin
        if (addr_reg == `ARRAY_INDEX_ADDR) begin
          word_next = idx_reg;
          state_next = ST_DATA;
        end else begin
          num_next = dec.num;
          rd_next = 1'b1;
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // Store answers while the read strobe is high
        if (dec.slot == 4'h0) begin
          word_next = PARAM_WIDE_IN ? PARAM_RDATA_IN[31:16]
            : PARAM_RDATA_IN[15:0];
        end else if (dec.slot == 4'h1 && PARAM_WIDE_IN) begin
          word_next = PARAM_RDATA_IN[15:0];
        end else begin
          word_next = 16'h0000; // Unmapped slot reads as zero
        end
        state_next = ST_DATA;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ==========================================================
  // Registers only
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      for (int i = 0; i < 8; i++) begin
        buf_reg[i] <= 8'h00;
      end
      rx_cnt_reg <= 4'h0;
      k_reg <= 4'h0;
      addr_reg <= 16'h0000;
      left_reg <= 16'h0000;
      word_reg <= 16'h0000;
      idx_reg <= `ARRAY_INDEX_RESET;
      tx_byte_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      num_reg <= 16'h0000;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
      low_reg <= 1'b0;
      wdata_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      buf_reg <= buf_next;
      rx_cnt_reg <= rx_cnt_next;
      k_reg <= k_next;
      addr_reg <= addr_next;
      left_reg <= left_next;
      word_reg <= word_next;
      idx_reg <= idx_next;
      tx_byte_reg <= tx_byte_next;
      tx_valid_reg <= tx_valid_next;
      num_reg <= num_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
      low_reg <= low_next;
      wdata_reg <= wdata_next;
    end
  end

  assign TX_BYTE_OUT = tx_byte_reg;
  assign TX_VALID_OUT = tx_valid_reg;
  assign PARAM_NUM_OUT = num_reg;
  assign PARAM_INDEX_OUT = idx_reg;
  assign PARAM_RD_OUT = rd_reg;
  assign PARAM_WR_OUT = wr_reg;
  assign PARAM_LOW_WORD_OUT = low_reg;
  assign PARAM_WDATA_OUT = wdata_reg;

  // ==========================================================
  // Checks
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!rst_n);

  chk_addr_map: assert property (
    PARAM_RD_OUT |-> (17'(PARAM_NUM_OUT) * 17'd10 == {1'b0, addr_reg} + 17'd1)
      || (17'(PARAM_NUM_OUT) * 17'd10 == {1'b0, addr_reg}))
    else $error("parameter number does not match register address");
  chk_echo_data: assert property (
    (state_reg == ST_HDR && buf_reg[1] == 8'h06 && $rose(TX_VALID_OUT))
      |-> TX_BYTE_OUT == buf_reg[k_reg[2:0]])
    else $error("write echo differs from request");
  chk_byte_count: assert property (
    (state_reg == ST_HDR && buf_reg[1] == 8'h03 && k_reg == 4'h2 && $rose(TX_VALID_OUT))
      |-> TX_BYTE_OUT == 8'(left_reg * 2))
    else $error("byte count is not twice register count");
  chk_wide_high: assert property (
    (state_reg == ST_WAIT && PARAM_WIDE_IN && dec.slot == 4'h0)
      |=> word_reg == $past(PARAM_RDATA_IN[31:16]) ##1 state_reg == ST_DATA)
    else $error("wide parameter high word not first");
  chk_narrow_word: assert property (
    (state_reg == ST_WAIT && !PARAM_WIDE_IN && dec.slot == 4'h0)
      |=> word_reg == $past(PARAM_RDATA_IN[15:0]))
    else $error("narrow parameter word wrong");
  chk_raw_high: assert property (
    (state_reg == ST_DATA && k_reg == 4'h0 && $rose(TX_VALID_OUT))
      |-> TX_BYTE_OUT == word_reg[15:8])
    else $error("data high byte not sent first");
  chk_index_store: assert property (
    (state_reg == ST_EXEC && buf_reg[1] == 8'h06 && req_addr == 16'h0008)
      |=> PARAM_INDEX_OUT == $past(req_word) && !PARAM_WR_OUT)
    else $error("array index not stored");
  chk_drop_bad: assert property (
    (state_reg == ST_CHECK && !frame_ok) |=> state_reg == ST_IDLE && !TX_VALID_OUT [*2])
    else $error("bad frame was answered");
  chk_tx_hold: assert property (
    (TX_VALID_OUT && !TX_READY_IN) |=> TX_VALID_OUT && $stable(TX_BYTE_OUT))
    else $error("transmit byte dropped before accept");

endmodule

// >>> sim/modbus_master_model.sv
// Serial master model: sends deframed request bytes, takes reply bytes.
// Assumes the bench builds whole frames, check bytes included.
`timescale 1ns/100ps

module modbus_master_model (
  input wire logic clk_in,
  input wire logic slow_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  output logic rx_end_out,
  output logic tx_ready_out
);
  // ==========================================================
  // Idle line at time zero
  initial begin
    rx_byte_out = 8'h00;
    rx_valid_out = 1'b0;
    rx_end_out = 1'b0;
  end

  // ==========================================================
  // Request side: one byte a cycle, then the gap marker
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      @(posedge clk_in);
      rx_byte_out <= f[i];  // Frame order as built
      rx_valid_out <= 1'b1;
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    // No stale byte once valid drops
    rx_byte_out <= ~rx_byte_out;
    rx_end_out <= 1'b1;  // Gap after the check bytes
    @(posedge clk_in);
    rx_end_out <= 1'b0;
  endtask

  // ==========================================================
  // Reply side: prompt, or stalling at random when slow
  always @(posedge clk_in) begin
    tx_ready_out <= !slow_in || ($urandom_range(1, 0) == 1);
  end
endmodule

// >>> sim/modbus_parameter_access_tb.sv
// Self-checking bench for the Modbus parameter access block.
// Assumes the master model drives the serial side and a store model here.
`timescale 1ns/100ps

module modbus_parameter_access_tb;
  typedef logic [7:0] bytes_t[$];  // Byte frame
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic [7:0] sa = 8'h01;  // Own station address
  logic [7:0] rx_byte, tx_byte;
  logic rx_valid, rx_end, tx_valid, tx_ready;
  logic [15:0] pnum, pidx, pwdata;
  logic prd, pwr, plow, pwide;
  logic [31:0] prdata;
  logic [7:0] eq[$];  // Expected reply bytes
  logic [32:0] wq[$];  // Expected writes {low, num, data}
  int fail_count = 0;
  int comparisons = 0;
  int n;
  bytes_t f;

  // ==========================================================
  // Clock and instances
  always #10 clk = ~clk;

  modbus_parameter_access u_dut (
    .CLOCK_IN(clk), .RESETN_IN(rstn), .SLAVE_ADDR_IN(sa),
    .RX_BYTE_IN(rx_byte), .RX_VALID_IN(rx_valid), .RX_END_IN(rx_end),
    .TX_BYTE_OUT(tx_byte), .TX_VALID_OUT(tx_valid), .TX_READY_IN(tx_ready),
    .PARAM_NUM_OUT(pnum), .PARAM_INDEX_OUT(pidx), .PARAM_RD_OUT(prd),
    .PARAM_RDATA_IN(prdata), .PARAM_WIDE_IN(pwide), .PARAM_WR_OUT(pwr),
    .PARAM_LOW_WORD_OUT(plow), .PARAM_WDATA_OUT(pwdata)
  );

  modbus_master_model u_master (
    .clk_in(clk), .slow_in(slow), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .rx_end_out(rx_end), .tx_ready_out(tx_ready)
  );

  // ==========================================================
  // Store model: raw values, zero latency
  always_comb begin
    pwide = (pnum == 16'h0202);  // Parameter 514 is wide
    if (pwide) begin
      prdata = 32'h0000012C;  // Raw count of hundredths
    end else if (pnum == 16'h0261) begin
      prdata = (pidx == 16'h0008) ? 32'h00000190 : 32'h00000000;
    end else begin
      prdata = {16'h0000, pnum ^ 16'h5A5A};
    end
  end

  // ==========================================================
  // Helpers
  task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reference check sum, reflected, low byte sent first
  function automatic bytes_t with_crc(bytes_t b);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    b.push_back(c[7:0]);
    b.push_back(c[15:8]);
    return b;
  endfunction

  function automatic bytes_t frm(logic [7:0] s, logic [7:0] fc, logic [15:0] a, logic [15:0] d);
    return with_crc({s, fc, a[15:8], a[7:0], d[15:8], d[7:0]});
  endfunction

  // Bounded wait until every noted result has shown up
  task automatic wait_idle();
    int k;
    k = 0;
    while ((eq.size() != 0 || wq.size() != 0) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 3000) begin
      fail_count++;
      $display("[ERR] %0t reply timed out", $time);
      print_verdict();
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    bytes_t b;
    logic [16:0] p;
    b = frm(sa, 8'h06, a, d);
    p = {1'b0, a} + 17'h00001;
    foreach (b[i]) eq.push_back(b[i]);  // Echo unchanged
    if (a != 16'h0008) wq.push_back({(p % 10) == 1, 16'(p / 10), d});
    u_master.send(b);
    wait_idle();
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] w[$]);
    bytes_t e;
    e = {sa, 8'h03, 8'(2 * w.size())};  // Count doubled
    foreach (w[i]) e = {e, w[i][15:8], w[i][7:0]};  // High byte first
    e = with_crc(e);
    foreach (e[i]) eq.push_back(e[i]);
    u_master.send(frm(sa, 8'h03, a, 16'(w.size())));
    wait_idle();
  endtask

  // Refused frame: nothing may come back
  task automatic drop(input bytes_t b);
    u_master.send(b);
    repeat (40) @(posedge clk);
  endtask

  // ==========================================================
  // Output watcher: oldest note against each result
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (eq.size() == 0) check(1, 0, "unexpected reply byte");
      else check(tx_byte, eq.pop_front(), "reply byte");
    end
    if (pwr === 1'b1) begin
      if (wq.size() == 0) check(1, 0, "unexpected write");
      else check({plow, pnum, pwdata}, wq.pop_front(), "write");
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(50620));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(16'h0008, '{16'h0000});  // Index reset value
    wr(16'h040F, 16'h003C);
    rd(16'h1413, '{16'h0000, 16'h012C});  // Wide, high word first
    wr(16'h0008, 16'h0008);
    check(pidx, 33'h8, "index register");
    rd(16'h0008, '{16'h0008});
    rd(16'h17C9, '{16'h0190});  // Selected element
    f = frm(sa, 8'h06, 16'h040F, 16'h1234);
    f[7] = ~f[7];
    drop(f);  // Bad check
    drop(frm(8'h02, 8'h06, 16'h040F, 16'h1234));  // Foreign station
    drop(frm(sa, 8'h05, 16'h040F, 16'h1234));
    drop(frm(sa, 8'h03, 16'h040F, 16'h0000));
    drop(frm(sa, 8'h03, 16'h040F, 16'h007E));
    // Random traffic, new station address, stalling transmitter
    sa <= 8'h2A;
    slow <= 1'b1;
    // Frames are built from sa, so let the new address land first
    @(posedge clk);
    repeat (6) begin
      n = $urandom_range(6553, 1);
      if (n == 514 || n == 609) n = 100;
      wr(16'(n * 10 - 1 + $urandom_range(1, 0)), 16'($urandom));
      rd(16'(n * 10 - 1), '{16'(n) ^ 16'h5A5A, 16'h0000});
    end
    print_verdict();
  end
endmodule
